// [design/srs_cfg.svh]
// Purpose: constants of the reset supervisor (offsets, fields, resets, times)
// Assumes: register byte address is four times the index
// Notes: times are in microseconds, clock rate in MHz
`ifndef SRS_CFG_SVH
`define SRS_CFG_SVH
`define SRS_CLK_MHZ 100
`define SRS_CNT_W 22
`define SRS_IDX_WDCTL 10'h000
`define SRS_IDX_MODE 10'h001
`define SRS_IDX_RSRC 10'h003
`define SRS_IDX_REGCTL 10'h010
`define SRS_IDX_SUPST 10'h01B
`define SRS_IDX_EVEN 10'h01C
`define SRS_IDX_EVT 10'h061
`define SRS_IDX_STARTUP 10'h073
`define SRS_IDX_SWDEV 10'h074
`define SRS_WMC_LSB 5
`define SRS_RLC_LSB 4
`define SRS_AUXSUC_BIT 3
`define SRS_SDM_BIT 2
`define SRS_WMC_AUTO 3'h1
`define SRS_WMC_TIMEOUT 3'h2
`define SRS_WMC_WINDOW 3'h4
`define SRS_WMC_RST 3'h4
`define SRS_STARTUP_RST 8'h00
`define SRS_SWDEV_RST 8'h00
`define SRS_AUX_OFF 2'h0
`define SRS_AUX_ALL 2'h3
`define SRS_TW_RST_00_US 20000
`define SRS_TW_RST_01_US 10000
`define SRS_TW_RST_10_US 3600
`define SRS_TW_RST_11_US 1000
`define SRS_TSTARTUP_US 1000
`define SRS_RS_NONE 4'h0
`define SRS_RS_V1UV 4'h1
`define SRS_RS_NVPROG 4'h2
`define SRS_RS_EXT 4'h3
`define SRS_RS_WD_WIN_OVF 4'h4
`define SRS_RS_WD_EARLY 4'h5
`define SRS_RS_WD_TO_OVF 4'h6
`define SRS_RS_WD_CHG 4'h7
`define SRS_RS_LEAVE_OFF 4'h8
`define SRS_RS_WAKE 4'h9
`define SRS_RS_DIAG_WAKE 4'hA
`define SRS_RS_LEAVE_OTP 4'hB
`define SRS_RS_ILL_SLEEP 4'hC
`define SRS_RS_FDE_WAKE 4'hD
`define SRS_RESP_OKAY 2'h0
`define SRS_RESP_SLVERR 2'h2
`endif

// [design/srs_pkg.sv]
// Purpose: types of the reset supervisor
// Assumes: nothing
// Notes: mode codes are also the values of the mode register
package srs_pkg;
  typedef enum logic [2:0] {
    SRS_OFF = 3'b000,
    SRS_RESET = 3'b001,
    SRS_STANDBY = 3'b010,
    SRS_NORMAL = 3'b011,
    SRS_SLEEP = 3'b100,
    SRS_OVERTEMP = 3'b101
  } srs_mode_t;
  typedef logic [3:0] srs_rsrc_t;
endpackage

// [design/srs_top.sv]
// Purpose: reset, mode and supervision logic of a system basis chip
// Assumes: all inputs synchronous to SYS_CLK_I; analog comparators outside
// Notes: reset line is open drain; OE high pulls it low
// Summary of operation
// RULE_01: watchdog mode field value 001 selects autonomous mode.
// RULE_02: autonomous: timeout in Normal or Standby with receive low, else off.
// RULE_03: autonomous wake-up forces receive pin low and restarts the watchdog.
// RULE_04: autonomous wake-up captured in Sleep moves the device to Standby.
// RULE_05: any system reset enters Reset mode and pulses the reset line low.
// RULE_06: the latest of thirteen reset sources is recorded.
// RULE_07: reset line is open drain; external low drive is a reset.
// RULE_08: external party holds the line low for the minimum pulse width.
// RULE_09: reset with main regulator undervoltage counts as cold start.
// RULE_10: cold start pulse width follows reset length field bits 5:4.
// RULE_11: warm start always uses the shortest pulse width, setting 11.
// RULE_12: at power-up auxiliary config loads 00 or 11 from bit 3.
// RULE_13: main undervoltage enters Reset except in Sleep or Overtemp.
// RULE_14: window overflow, early trigger, or pending-fail timeout overflow resets.
// RULE_15: rewriting watchdog control in Normal mode causes a reset.
// RULE_16: leaving Off/Overtemp, programming, sleep wake-ups, illegal sleep reset.
// RULE_17: overtemperature outside Sleep/Off enters Overtemp, drives line low, supplies off.
// RULE_18: below release threshold Overtemp goes through Reset to Standby.
// RULE_19: above warning threshold set warning status and capture warning event.
// RULE_20: low battery enters Off; 5 V main regulator stays on above 2 V.
// RULE_21: battery up plus start-up delay moves Off to Reset, sets power-on event.
// RULE_22: main regulator below 90 % raises enabled event; status shows level.
// RULE_23: timeout overflow captures failure; reset only if failure already pending.
// RULE_24: line held low full width; new source restarts the pulse timer.
`include "srs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module srs_top #(
  parameter int unsigned RST_CYC_00 = `SRS_TW_RST_00_US * `SRS_CLK_MHZ,
  parameter int unsigned RST_CYC_01 = `SRS_TW_RST_01_US * `SRS_CLK_MHZ,
  parameter int unsigned RST_CYC_10 = `SRS_TW_RST_10_US * `SRS_CLK_MHZ,
  parameter int unsigned RST_CYC_11 = `SRS_TW_RST_11_US * `SRS_CLK_MHZ,
  parameter int unsigned STARTUP_CYC = `SRS_TSTARTUP_US * `SRS_CLK_MHZ,
  parameter bit VARIANT_5V = 1'b1
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [11:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [11:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic RESET_LINE_I,
  output logic RESET_LINE_O,
  output logic RESET_LINE_OE_O,
  input wire logic BAT_PON_I,
  input wire logic BAT_POFF_I,
  input wire logic BAT_BELOW_2V_I,
  input wire logic MAIN_UV_I,
  input wire logic MAIN_BELOW_90_I,
  input wire logic TEMP_OTP_ACT_I,
  input wire logic TEMP_OTP_REL_I,
  input wire logic TEMP_WARN_I,
  input wire logic RXD_LOW_I,
  input wire logic WAKE_LOCAL_I,
  input wire logic WAKE_BUS_I,
  input wire logic WAKE_DIAG_I,
  input wire logic WAKE_FDE_I,
  input wire logic WD_WIN_OVF_I,
  input wire logic WD_EARLY_I,
  input wire logic WD_TO_OVF_I,
  input wire logic NV_PROG_DONE_I,
  output logic [2:0] MODE_O,
  output logic WD_TIMEOUT_O,
  output logic WD_WINDOW_O,
  output logic WD_RESTART_O,
  output logic RXD_FORCE_LOW_O,
  output logic MAIN_REG_EN_O,
  output logic AUX_REG_EN_O,
  output logic XCVR_EN_O,
  output logic [1:0] MAIN_THRESH_O
);
  localparam int CW = `SRS_CNT_W;

  srs_pkg::srs_mode_t mode_q, mode_d;
  logic aw_q, w_q, bvalid_q, rvalid_q;
  logic [9:0] awidx_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [2:0] wmc_q;
  logic [2:0] startup_q;
  logic sdm_q, uv_en_q;
  logic [1:0] aux_cfg_q, thresh_q;
  logic po_q, otw_q, uvw_q, wdf_q, wake_q;
  logic overtemp_warn_status_q, b90_q, nvp_q, drv_q, drv_prev_q, wd_rst_q;
  logic cold_q;
  srs_pkg::srs_rsrc_t rsrc_q, src;
  logic [CW-1:0] cnt_q, pcnt_q;
  logic cold, do_wr, auto, to_on, pon_done, wake_any, wake_set;
  logic ext_low, mon, ill_sleep, wd_chg;
  logic [7:0] rd;

  function automatic logic srs_hit(input logic [9:0] idx);
    case (idx)
      `SRS_IDX_WDCTL, `SRS_IDX_MODE, `SRS_IDX_RSRC, `SRS_IDX_REGCTL,
      `SRS_IDX_SUPST, `SRS_IDX_EVEN, `SRS_IDX_EVT, `SRS_IDX_STARTUP,
      `SRS_IDX_SWDEV: srs_hit = 1'b1;
      default: srs_hit = 1'b0;
    endcase
  endfunction

  // pulse length in cycles minus one; warm start always takes setting 11
  function automatic logic [CW-1:0] srs_len(input logic [1:0] sel, input logic c);
    case (c ? sel : 2'h3)
      2'h0: srs_len = CW'(RST_CYC_00 - 1);
      2'h1: srs_len = CW'(RST_CYC_01 - 1);
      2'h2: srs_len = CW'(RST_CYC_10 - 1);
      default: srs_len = CW'(RST_CYC_11 - 1);
    endcase
  endfunction

  // ---------------- AXI4-Lite slave ----------------
  assign S_AXI_AWREADY_O = ~aw_q & ~bvalid_q;
  assign S_AXI_WREADY_O = ~w_q & ~bvalid_q;
  assign S_AXI_ARREADY_O = ~rvalid_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign do_wr = aw_q & w_q;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `SRS_RESP_OKAY;
      awidx_q <= 10'h000;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_q <= 1'b1;
        awidx_q <= S_AXI_AWADDR_I[11:2];
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_q <= 1'b1;
        wdata_q <= S_AXI_WDATA_I[7:0];
        wstrb_q <= S_AXI_WSTRB_I[0];
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= srs_hit(awidx_q) ? `SRS_RESP_OKAY : `SRS_RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY_I) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd = 8'h00;
    case (S_AXI_ARADDR_I[11:2])
      `SRS_IDX_WDCTL: rd = {wmc_q, 5'h00};
      `SRS_IDX_MODE: rd = {5'h00, mode_q};
      `SRS_IDX_RSRC: rd = {cold_q, 3'h0, rsrc_q};
      `SRS_IDX_REGCTL: rd = {4'h0, aux_cfg_q, thresh_q};
      `SRS_IDX_SUPST: rd = {5'h00, to_on, overtemp_warn_status_q, b90_q};
      `SRS_IDX_EVEN: rd = {7'h00, uv_en_q};
      `SRS_IDX_EVT: rd = {3'h0, wake_q, wdf_q, uvw_q, otw_q, po_q};
      `SRS_IDX_STARTUP: rd = {2'h0, startup_q, 3'h0};
      `SRS_IDX_SWDEV: rd = {5'h00, sdm_q, 2'h0};
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SRS_RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd};
      rresp_q <= srs_hit(S_AXI_ARADDR_I[11:2]) ? `SRS_RESP_OKAY : `SRS_RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY_I) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- watchdog gating ----------------
  assign auto = (wmc_q == `SRS_WMC_AUTO); // RULE_01
  always_comb begin
    to_on = 1'b0;
    case (wmc_q)
      `SRS_WMC_AUTO: to_on = ~sdm_q & ((mode_q == srs_pkg::SRS_NORMAL) |
        ((mode_q == srs_pkg::SRS_STANDBY) & (RXD_LOW_I | wake_q))); // RULE_02
      `SRS_WMC_TIMEOUT: to_on = (mode_q == srs_pkg::SRS_NORMAL) |
        (mode_q == srs_pkg::SRS_STANDBY) | (mode_q == srs_pkg::SRS_SLEEP);
      `SRS_WMC_WINDOW: to_on = (mode_q == srs_pkg::SRS_STANDBY) |
        (mode_q == srs_pkg::SRS_SLEEP);
      default: to_on = 1'b0;
    endcase
  end
  assign WD_TIMEOUT_O = to_on;
  assign WD_WINDOW_O = (wmc_q == `SRS_WMC_WINDOW) & (mode_q == srs_pkg::SRS_NORMAL);
  assign WD_RESTART_O = wd_rst_q;
  assign RXD_FORCE_LOW_O = wake_q & auto; // RULE_03

  // ---------------- reset sources ----------------
  assign wake_any = WAKE_LOCAL_I | WAKE_BUS_I | WAKE_DIAG_I | WAKE_FDE_I;
  assign wake_set = auto & wake_any & ((mode_q == srs_pkg::SRS_NORMAL) |
    (mode_q == srs_pkg::SRS_STANDBY) | (mode_q == srs_pkg::SRS_SLEEP)); // RULE_03
  // the line is released one cycle before it is watched again, so the pull-up
  // has time to lift it before an external low is believed
  assign ext_low = ~RESET_LINE_I & ~drv_q & ~drv_prev_q; // RULE_07
  assign wd_chg = do_wr & wstrb_q & (awidx_q == `SRS_IDX_WDCTL) &
    (mode_q == srs_pkg::SRS_NORMAL); // RULE_15
  assign ill_sleep = do_wr & wstrb_q & (awidx_q == `SRS_IDX_MODE) &
    (wdata_q[2:0] == srs_pkg::SRS_SLEEP) & wake_q;
  assign pon_done = BAT_PON_I & (pcnt_q == CW'(STARTUP_CYC - 1)); // RULE_21
  assign mon = (mode_q != srs_pkg::SRS_SLEEP) & (mode_q != srs_pkg::SRS_OFF);

  always_comb begin
    src = `SRS_RS_NONE;
    cold = 1'b0;
    case (mode_q)
      srs_pkg::SRS_OFF: begin
        if (pon_done) begin
          src = nvp_q ? `SRS_RS_NVPROG : `SRS_RS_LEAVE_OFF; // RULE_16
        end
        cold = 1'b1;
      end
      srs_pkg::SRS_OVERTEMP: begin
        if (TEMP_OTP_REL_I) begin
          src = `SRS_RS_LEAVE_OTP; // RULE_18
        end
        cold = 1'b1;
      end
      default: begin
        if (MAIN_UV_I && mode_q != srs_pkg::SRS_SLEEP) begin
          src = `SRS_RS_V1UV; // RULE_13
        end else if (ext_low) begin
          src = `SRS_RS_EXT; // RULE_07
        end else if (WD_WIN_OVF_I) begin
          src = `SRS_RS_WD_WIN_OVF; // RULE_14
        end else if (WD_EARLY_I) begin
          src = `SRS_RS_WD_EARLY; // RULE_14
        end else if (WD_TO_OVF_I && wdf_q) begin
          src = `SRS_RS_WD_TO_OVF; // RULE_23
        end else if (wd_chg) begin
          src = `SRS_RS_WD_CHG; // RULE_15
        end else if (mode_q == srs_pkg::SRS_SLEEP && !auto) begin
          if (WAKE_LOCAL_I || WAKE_BUS_I) begin
            src = `SRS_RS_WAKE; // RULE_16
          end else if (WAKE_DIAG_I) begin
            src = `SRS_RS_DIAG_WAKE;
          end else if (WAKE_FDE_I) begin
            src = `SRS_RS_FDE_WAKE;
          end
        end else if (ill_sleep) begin
          src = `SRS_RS_ILL_SLEEP; // RULE_16
        end
        // undervoltage before or during Reset keeps the start cold
        cold = MAIN_UV_I | (mode_q == srs_pkg::SRS_SLEEP) |
          ((mode_q == srs_pkg::SRS_RESET) & cold_q); // RULE_09
      end
    endcase
  end

  // ---------------- mode sequencing ----------------
  always_comb begin
    mode_d = mode_q;
    if (BAT_POFF_I || NV_PROG_DONE_I) begin
      mode_d = srs_pkg::SRS_OFF; // RULE_20
    end else if (TEMP_OTP_ACT_I && mon && mode_q != srs_pkg::SRS_OVERTEMP) begin
      mode_d = srs_pkg::SRS_OVERTEMP; // RULE_17
    end else if (src != `SRS_RS_NONE) begin
      mode_d = srs_pkg::SRS_RESET; // RULE_05
    end else begin
      case (mode_q)
        srs_pkg::SRS_RESET: begin
          if (cnt_q == '0) begin
            mode_d = srs_pkg::SRS_STANDBY; // RULE_18
          end
        end
        srs_pkg::SRS_NORMAL, srs_pkg::SRS_STANDBY: begin
          if (do_wr && wstrb_q && awidx_q == `SRS_IDX_MODE) begin
            case (wdata_q[2:0])
              srs_pkg::SRS_NORMAL: mode_d = srs_pkg::SRS_NORMAL;
              srs_pkg::SRS_STANDBY: mode_d = srs_pkg::SRS_STANDBY;
              srs_pkg::SRS_SLEEP: mode_d = srs_pkg::SRS_SLEEP;
              default: mode_d = mode_q;
            endcase
          end
        end
        srs_pkg::SRS_SLEEP: begin
          if (wake_set) begin
            mode_d = srs_pkg::SRS_STANDBY; // RULE_04
          end
        end
        default: mode_d = mode_q;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mode_q <= srs_pkg::SRS_OFF;
      drv_q <= 1'b1;
      drv_prev_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      drv_q <= (mode_d == srs_pkg::SRS_RESET) | (mode_d == srs_pkg::SRS_OVERTEMP) |
        (mode_d == srs_pkg::SRS_OFF); // RULE_17
      drv_prev_q <= drv_q;
    end
  end

  // pulse timer restarts on every new source while the pulse runs
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cnt_q <= '0;
      rsrc_q <= `SRS_RS_NONE;
      cold_q <= 1'b0;
    end else if (src != `SRS_RS_NONE && mode_d == srs_pkg::SRS_RESET) begin
      cnt_q <= srs_len(startup_q[`SRS_RLC_LSB-3 +: 2], cold); // RULE_24 RULE_10 RULE_11
      rsrc_q <= src; // RULE_06
      cold_q <= cold; // RULE_09
    end else if (mode_q == srs_pkg::SRS_RESET && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1; // RULE_24
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pcnt_q <= '0;
    end else if (mode_q != srs_pkg::SRS_OFF || !BAT_PON_I) begin
      pcnt_q <= '0;
    end else if (!pon_done) begin
      pcnt_q <= pcnt_q + 1'b1; // RULE_21
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nvp_q <= 1'b0;
    end else if (NV_PROG_DONE_I) begin
      nvp_q <= 1'b1;
    end else if (mode_q == srs_pkg::SRS_OFF && pon_done) begin
      nvp_q <= 1'b0;
    end
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wmc_q <= `SRS_WMC_RST;
      startup_q <= 3'(`SRS_STARTUP_RST >> 3);
      sdm_q <= 1'(`SRS_SWDEV_RST >> `SRS_SDM_BIT);
      uv_en_q <= 1'b0;
      thresh_q <= 2'h0;
    end else if (do_wr && wstrb_q) begin
      case (awidx_q)
        `SRS_IDX_WDCTL: begin
          if (mode_q != srs_pkg::SRS_NORMAL) begin
            wmc_q <= wdata_q[`SRS_WMC_LSB +: 3];
          end
        end
        `SRS_IDX_STARTUP: startup_q <= wdata_q[5:3];
        `SRS_IDX_SWDEV: sdm_q <= wdata_q[`SRS_SDM_BIT];
        `SRS_IDX_EVEN: uv_en_q <= wdata_q[0];
        `SRS_IDX_REGCTL: thresh_q <= wdata_q[1:0];
        default: uv_en_q <= uv_en_q;
      endcase
    end
  end

  // power-up load wins over a software write in the same cycle
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aux_cfg_q <= `SRS_AUX_OFF;
    end else if (mode_q == srs_pkg::SRS_OFF && pon_done) begin
      aux_cfg_q <= startup_q[`SRS_AUXSUC_BIT-3] ? `SRS_AUX_ALL : `SRS_AUX_OFF; // RULE_12
    end else if (do_wr && wstrb_q && awidx_q == `SRS_IDX_REGCTL) begin
      aux_cfg_q <= wdata_q[3:2];
    end
  end

  // ---------------- status and events (events write one to clear, set wins) ----------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      po_q <= 1'b0;
      otw_q <= 1'b0;
      uvw_q <= 1'b0;
      wdf_q <= 1'b0;
      wake_q <= 1'b0;
      overtemp_warn_status_q <= 1'b0;
      b90_q <= 1'b0;
      wd_rst_q <= 1'b0;
    end else begin
      overtemp_warn_status_q <= TEMP_WARN_I & mon; // RULE_19
      b90_q <= MAIN_BELOW_90_I; // RULE_22
      wd_rst_q <= wake_set; // RULE_03
      if (mode_q == srs_pkg::SRS_OFF && pon_done) begin
        po_q <= 1'b1; // RULE_21
      end else if (do_wr && wstrb_q && awidx_q == `SRS_IDX_EVT && wdata_q[0]) begin
        po_q <= 1'b0;
      end
      if (TEMP_WARN_I && mon && !overtemp_warn_status_q) begin
        otw_q <= 1'b1; // RULE_19
      end else if (do_wr && wstrb_q && awidx_q == `SRS_IDX_EVT && wdata_q[1]) begin
        otw_q <= 1'b0;
      end
      if (MAIN_BELOW_90_I && !b90_q && uv_en_q) begin
        uvw_q <= 1'b1; // RULE_22
      end else if (do_wr && wstrb_q && awidx_q == `SRS_IDX_EVT && wdata_q[2]) begin
        uvw_q <= 1'b0;
      end
      if (WD_TO_OVF_I) begin
        wdf_q <= 1'b1; // RULE_23
      end else if (do_wr && wstrb_q && awidx_q == `SRS_IDX_EVT && wdata_q[3]) begin
        wdf_q <= 1'b0;
      end
      if (wake_set) begin
        wake_q <= 1'b1;
      end else if (do_wr && wstrb_q && awidx_q == `SRS_IDX_EVT && wdata_q[4]) begin
        wake_q <= 1'b0;
      end
    end
  end

  // ---------------- supply and pin outputs ----------------
  assign MODE_O = mode_q;
  assign RESET_LINE_O = 1'b0;
  assign RESET_LINE_OE_O = drv_q; // RULE_05
  // main regulator also feeds the external transistor, so aux settings 10 and 11 go off with it, but 11 stays on in Sleep
  assign MAIN_REG_EN_O = (mode_q == srs_pkg::SRS_NORMAL) |
    (mode_q == srs_pkg::SRS_STANDBY) | (mode_q == srs_pkg::SRS_RESET) |
    ((mode_q == srs_pkg::SRS_OFF) & VARIANT_5V & ~BAT_BELOW_2V_I); // RULE_20 RULE_17
  always_comb begin
    AUX_REG_EN_O = 1'b0;
    case (aux_cfg_q)
      2'h1: AUX_REG_EN_O = (mode_q == srs_pkg::SRS_NORMAL);
      2'h2: AUX_REG_EN_O = MAIN_REG_EN_O & (mode_q != srs_pkg::SRS_OFF);
      2'h3: AUX_REG_EN_O = (MAIN_REG_EN_O & (mode_q != srs_pkg::SRS_OFF)) |
        (mode_q == srs_pkg::SRS_SLEEP);
      default: AUX_REG_EN_O = 1'b0;
    endcase
  end
  assign XCVR_EN_O = (mode_q == srs_pkg::SRS_NORMAL);
  assign MAIN_THRESH_O = thresh_q;
endmodule
`default_nettype wire

// [sim/srs_top_asserts.sv]
// Purpose: port-level assertions of the reset supervisor
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound into srs_top at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module srs_top_chk (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [2:0] MODE_O,
  input wire logic RESET_LINE_O,
  input wire logic RESET_LINE_OE_O,
  input wire logic MAIN_REG_EN_O,
  input wire logic AUX_REG_EN_O,
  input wire logic XCVR_EN_O,
  input wire logic BAT_POFF_I,
  input wire logic NV_PROG_DONE_I,
  input wire logic MAIN_UV_I,
  input wire logic TEMP_OTP_ACT_I,
  input wire logic TEMP_OTP_REL_I,
  input wire logic WD_EARLY_I
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic calm;
  // off and programming override every other source
  assign calm = !BAT_POFF_I && !NV_PROG_DONE_I;
  property p_rst_drive;
    MODE_O == 3'h1 |-> RESET_LINE_OE_O;
  endproperty
  a_rst_drive: assert property (p_rst_drive) else $error("reset mode, line free");
  property p_otp_off;
    MODE_O == 3'h5 |-> RESET_LINE_OE_O && !MAIN_REG_EN_O && !AUX_REG_EN_O && !XCVR_EN_O;
  endproperty
  a_otp_off: assert property (p_otp_off) else $error("overtemp, supply on");
  property p_early;
    WD_EARLY_I && calm && !TEMP_OTP_ACT_I && MODE_O inside {3'h2, 3'h3} |=> MODE_O == 3'h1;
  endproperty
  a_early: assert property (p_early) else $error("early trigger ignored");
  property p_uv;
    MAIN_UV_I && calm && !TEMP_OTP_ACT_I && MODE_O inside {3'h2, 3'h3} ##1 1'b1 |-> MODE_O == 3'h1;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage ignored");
  property p_otp_in;
    TEMP_OTP_ACT_I && calm && MODE_O inside {3'h1, 3'h2, 3'h3} |=> MODE_O == 3'h5;
  endproperty
  a_otp_in: assert property (p_otp_in) else $error("overtemp not entered");
  property p_otp_out;
    MODE_O == 3'h5 && TEMP_OTP_REL_I && !TEMP_OTP_ACT_I && calm |=> MODE_O == 3'h1;
  endproperty
  a_otp_out: assert property (p_otp_out) else $error("overtemp not left");
  property p_poff;
    BAT_POFF_I |=> MODE_O == 3'h0 && RESET_LINE_OE_O;
  endproperty
  a_poff: assert property (p_poff) else $error("battery loss ignored");
  property p_od;
    !RESET_LINE_O;
  endproperty
  a_od: assert property (p_od) else $error("reset line driven high");
endmodule
bind srs_top srs_top_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .MODE_O(MODE_O),
  .RESET_LINE_O(RESET_LINE_O), .RESET_LINE_OE_O(RESET_LINE_OE_O), .XCVR_EN_O(XCVR_EN_O),
  .MAIN_REG_EN_O(MAIN_REG_EN_O), .AUX_REG_EN_O(AUX_REG_EN_O), .BAT_POFF_I(BAT_POFF_I),
  .NV_PROG_DONE_I(NV_PROG_DONE_I), .MAIN_UV_I(MAIN_UV_I), .TEMP_OTP_ACT_I(TEMP_OTP_ACT_I),
  .TEMP_OTP_REL_I(TEMP_OTP_REL_I), .WD_EARLY_I(WD_EARLY_I));
`default_nettype wire

// [sim/srs_host_model.sv]
// Purpose: host controller on the open-drain reset wire
// Assumes: wire has a pull-up, either party may pull it low
// Notes: a start request pulls the wire for HOLD cycles
`timescale 1ns/100ps
`default_nettype none
module srs_host_model #(
  parameter int HOLD = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic dut_oe_i,
  input wire logic start_i,
  output logic line_o
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_q <= 8'h00;
    else if (start_i) cnt_q <= 8'(HOLD);
    else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  end
  // pull-up wins only when nobody pulls
  assign line_o = !(dut_oe_i || cnt_q != 8'h00);
endmodule
`default_nettype wire

// [sim/srs_top_tb_top.sv]
// Purpose: self-checking bench of the reset supervisor
// Assumes: shortened pulse counts 20/15/10/5, start-up 8
// Notes: inputs live in one vector, bit 17 starts the host pull
`include "srs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module srs_top_tb_top;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [11:0] aa = 12'h000, ra = 12'h000;
  logic [31:0] wd = 32'h0, rd;
  logic [17:0] inp = 18'h0;
  logic awr, wr, bv, arr, rv, oe, line, men, wto, rxf, wrs, xen;
  logic [1:0] br, rr;
  logic [2:0] mode;
  int errors = 0, check_count = 0;
  always #5 clk = ~clk;
  srs_top #(.RST_CYC_00(20), .RST_CYC_01(15), .RST_CYC_10(10), .RST_CYC_11(5),
    .STARTUP_CYC(8), .VARIANT_5V(1'b1)) dut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(aa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'h1), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(br),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ra), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rry), .RESET_LINE_I(line), .RESET_LINE_O(), .RESET_LINE_OE_O(oe),
    .BAT_PON_I(inp[0]), .BAT_POFF_I(inp[1]), .BAT_BELOW_2V_I(inp[2]), .MAIN_UV_I(inp[3]),
    .MAIN_BELOW_90_I(inp[4]), .TEMP_OTP_ACT_I(inp[5]), .TEMP_OTP_REL_I(inp[6]),
    .TEMP_WARN_I(inp[7]), .RXD_LOW_I(inp[8]), .WAKE_LOCAL_I(inp[9]), .WAKE_BUS_I(inp[10]),
    .WAKE_DIAG_I(inp[11]), .WAKE_FDE_I(inp[12]), .WD_WIN_OVF_I(inp[13]),
    .WD_EARLY_I(inp[14]), .WD_TO_OVF_I(inp[15]), .NV_PROG_DONE_I(inp[16]), .MODE_O(mode),
    .WD_TIMEOUT_O(wto), .WD_WINDOW_O(), .WD_RESTART_O(wrs), .RXD_FORCE_LOW_O(rxf),
    .MAIN_REG_EN_O(men), .AUX_REG_EN_O(), .XCVR_EN_O(xen), .MAIN_THRESH_O());
  srs_host_model #(.HOLD(4)) host (.clk_i(clk), .rst_n_i(rst_n), .dut_oe_i(oe),
    .start_i(inp[17]), .line_o(line));
  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // handshakes are judged on values settled at the falling edge before the rising one
  task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    aa <= {idx, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(negedge clk);
      {ta, tw, tb, r} = {awr, wr, bv, br};
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (tb !== 1'b1);
  endtask
  task automatic axi_rd(input logic [9:0] idx, output logic [7:0] d, output logic [1:0] r);
    logic ta, tb;
    ra <= {idx, 2'h0};
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(negedge clk);
      {ta, tb, r, d} = {arr, rv, rr, rd[7:0]};
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (tb !== 1'b1);
  endtask
  task automatic pulse(input int b);
    inp[b] <= 1'b1;
    @(posedge clk);
    inp[b] <= 1'b0;
  endtask
  // counts the cycles spent in Reset mode, then reads the recorded source
  task automatic rst_len(input int exp, input logic [7:0] src);
    int n;
    logic [7:0] d;
    logic [1:0] r;
    n = 0;
    while (mode !== 3'h1) @(negedge clk);
    while (mode === 3'h1) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    check("pulse width", n, exp);
    axi_rd(`SRS_IDX_RSRC, d, r);
    check("reset source", d, src);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] d;
    logic [1:0] r;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axi_rd(`SRS_IDX_STARTUP, d, r);
    check("startup reset", d, `SRS_STARTUP_RST);
    axi_wr(`SRS_IDX_STARTUP, 8'hCF, r);
    axi_rd(`SRS_IDX_STARTUP, d, r);
    check("startup", d, 8'h08);
    inp[0] <= 1'b1;
    rst_len(20, 8'h88);
    axi_rd(`SRS_IDX_EVT, d, r);
    check("power-on event", d[0], 1'b1);
    axi_rd(`SRS_IDX_REGCTL, d, r);
    check("aux config", d[3:2], `SRS_AUX_ALL);
    pulse(14);
    rst_len(5, 8'h05);
    pulse(17);
    rst_len(5, 8'h03);
    axi_wr(`SRS_IDX_STARTUP, 8'h20, r);
    pulse(3);
    rst_len(10, 8'h81);
    inp[5] <= 1'b1;
    repeat (3) @(negedge clk);
    check("overtemp mode", mode, 3'h5);
    check("main regulator", men, 1'b0);
    check("transceiver", xen, 1'b0);
    @(posedge clk);
    inp[5] <= 1'b0;
    inp[6] <= 1'b1;
    rst_len(10, 8'h8B);
    inp[6] <= 1'b0;
    inp[7] <= 1'b1;
    inp[4] <= 1'b1;
    repeat (2) @(posedge clk);
    axi_rd(`SRS_IDX_SUPST, d, r);
    check("supply status", d[1:0], 2'h3);
    axi_rd(10'h3FF, d, r);
    check("unmapped", r, `SRS_RESP_SLVERR);
    axi_wr(`SRS_IDX_WDCTL, 8'h20, r);
    @(negedge clk);
    check("wd auto idle", wto, 1'b0);
    @(posedge clk);
    pulse(9);
    @(negedge clk);
    check("wd auto wake", wto, 1'b1);
    check("rxd forced", rxf, 1'b1);
    check("wd restart", wrs, 1'b1);
    @(posedge clk);
    inp[1] <= 1'b1;
    repeat (3) @(negedge clk);
    check("off mode", mode, 3'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
